// ---- fos_pkg.sv ----
package fos_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFS_USER_CONFIG = 8'h00;
	localparam logic [7:0] OFS_EPP_STATUS = 8'h04;
	localparam logic [7:0] OFS_PLIB_A = 8'h08;
	localparam logic [7:0] OFS_PLIB_B = 8'h0C;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_LOAD_CTRL = 8'h18;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int POS_HIGH_LEVEL = 26;
	localparam int POS_USER_ONE = 18;
	localparam int POS_USER_ZERO = 10;
	localparam int POS_SYS_BYTE = 2;
	localparam int POS_ACCESS_PROT = 1;
	localparam int POS_USD_ERR = 0;
	localparam int POS_EXT_DATA_START = 16;
	localparam int POS_MAIN_LIB_EN = 3;
	localparam int POS_EXT_LIB_EN = 2;
	localparam int POS_BOOT_APP = 0;
	localparam int POS_LIB_END = 22;
	localparam int POS_LIB_DATA_START = 11;
	localparam int POS_LIB_START = 0;

	// ----------------------------------------
	// Codes and reset values
	// ----------------------------------------
	localparam logic [7:0] PROT_CODE_OFF = 8'hA5;
	localparam logic [7:0] PROT_CODE_HIGH = 8'hCC;
	localparam logic [7:0] BYTE_FORCED = 8'hFF;
	localparam logic [31:0] EPP_RESET = 32'hFFFF_FFFF;
	localparam logic [9:0] LIB_END_RESET = 10'h3FF;
	localparam logic [10:0] LIB_DATA_NONE = 11'h7FF;
	localparam logic [7:0] EXT_DATA_NONE = 8'hFF;
	localparam logic [10:0] LIB_START_RESET = 11'h000;

	// Load words, fetched one per cycle from the configuration store
	localparam int LOAD_WORDS = 4;
	localparam int IRQ_BITS = 2;
endpackage : fos_pkg

// ---- fos_byte_check.sv ----
`timescale 1ns/1ps
`default_nettype none
// Checks a stored byte against its inverse; forces the byte value to all ones on mismatch
module fos_byte_check
(
	input wire logic [7:0] raw,
	input wire logic [7:0] raw_inv,
	output logic [7:0] value,
	output logic bad
);
	always_comb
	begin
		bad = (raw != ~raw_inv);
		value = bad ? fos_pkg::BYTE_FORCED : raw;
	end
endmodule : fos_byte_check
`default_nettype wire

// ---- fos_status.sv ----
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Protection level from high-level bit and protection bit; A5 off, CC high.
// - Flash accesses are refused while the access protection bit is set.
// - Byte not matching its inverse sets error flag and reads as FF.
// - User bytes in 25:18 and 17:10, system byte in 9:2.
// - Erase/program protection word mirrors loaded data, resets to all ones.
// - Extension data start sector in 23:16; zero invalid, all ones none.
// - Main library enable flag set when main flash holds protected code.
// - Extension library flag needs boot-area application flag and protected code; set here from boot flag and extension start not FF alone.
// - Boot-area application flag shows boot memory may hold application code.
// - Library end sector in 31:22, resets to all ones.
// - Library data start sector in 21:11; zero invalid, all ones none.
// - Library start sector in 10:0, resets to zero.
module fos_status
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	input wire logic [31:0] cfg_data,
	output logic [1:0] cfg_index,
	input wire logic flash_req,
	output logic flash_grant,
	output logic flash_refused,
	output logic load_done,
	output logic irq
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'b001,
		ST_LOAD = 3'b010,
		ST_DONE = 3'b100
	} fos_state_e;

	typedef struct packed
	{
		logic rst_m;
		logic rst_s;
		fos_state_e st;
		logic [1:0] idx;
		logic [7:0] prot_code;
		logic [7:0] user_one;
		logic [7:0] user_zero;
		logic [7:0] sys_byte;
		logic usd_err;
		logic [31:0] epp;
		logic [7:0] ext_data_start;
		logic main_lib_en;
		logic ext_lib_en;
		logic boot_app;
		logic [9:0] lib_end;
		logic [10:0] lib_data_start;
		logic [10:0] lib_start;
		logic [1:0] irq_sts;
		logic [1:0] irq_mask;
		logic [31:0] rdata;
		logic grant;
		logic refused;
		logic done;
		logic irq;
	} fos_state_s;

	fos_state_s s_q;
	fos_state_s s_d;

	// ----------------------------------------
	// Integrity checks on loaded bytes
	// ----------------------------------------
	// Word 0: [7:0] protection code, [15:8] its inverse, [23:16] system byte, [31:24] inverse
	// Word 1: [7:0] user zero, [15:8] inverse, [23:16] user one, [31:24] inverse
	logic [7:0] chk_val [2];
	logic [1:0] chk_bad;
	logic [7:0] chk_raw [2];
	logic [7:0] chk_inv [2];

	always_comb
	begin
		chk_raw[0] = cfg_data[7:0];
		chk_inv[0] = cfg_data[15:8];
		chk_raw[1] = cfg_data[23:16];
		chk_inv[1] = cfg_data[31:24];
	end

	for (genvar g = 0; g < 2; g++)
	begin : g_chk
		fos_byte_check u_chk
		(
			.raw(chk_raw[g]),
			.raw_inv(chk_inv[g]),
			.value(chk_val[g]),
			.bad(chk_bad[g])
		);
	end

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic [1:0] prot_level(input logic [7:0] code);
		if (code == fos_pkg::PROT_CODE_OFF)
			prot_level = 2'b00;
		else if (code == fos_pkg::PROT_CODE_HIGH)
			prot_level = 2'b11;
		else
			prot_level = 2'b01;
	endfunction : prot_level

	function automatic logic [31:0] user_word(input fos_state_s s);
		logic [1:0] lvl;
		lvl = prot_level(s.prot_code);
		user_word = 32'h0000_0000;
		user_word[fos_pkg::POS_HIGH_LEVEL] = lvl[1];
		user_word[fos_pkg::POS_USER_ONE +: 8] = s.user_one;
		user_word[fos_pkg::POS_USER_ZERO +: 8] = s.user_zero;
		user_word[fos_pkg::POS_SYS_BYTE +: 8] = s.sys_byte;
		user_word[fos_pkg::POS_ACCESS_PROT] = lvl[0];
		user_word[fos_pkg::POS_USD_ERR] = s.usd_err;
	endfunction : user_word

	logic [1:0] level_now;
	assign level_now = prot_level(s_q.prot_code);
	logic [1:0] irq_set;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb
	begin
		s_d = s_q;
		s_d.rst_m = 1'b1;
		s_d.rst_s = s_q.rst_m;
		s_d.done = 1'b0;
		irq_set = 2'b00;
		case (s_q.st)
			ST_IDLE:
			begin
				s_d.idx = 2'b00;
				s_d.st = ST_LOAD;
			end
			ST_LOAD:
			begin
				case (s_q.idx)
					2'd0:
					begin
						s_d.prot_code = chk_val[0];
						s_d.sys_byte = chk_val[1];
						s_d.usd_err = chk_bad[0] | chk_bad[1];
					end
					2'd1:
					begin
						s_d.user_zero = chk_val[0];
						s_d.user_one = chk_val[1];
						s_d.usd_err = s_q.usd_err | chk_bad[0] | chk_bad[1];
					end
					2'd2:
						s_d.epp = cfg_data;
					default:
					begin
						s_d.lib_end = cfg_data[fos_pkg::POS_LIB_END +: 10];
						s_d.lib_data_start = cfg_data[fos_pkg::POS_LIB_DATA_START +: 11];
						s_d.lib_start = cfg_data[fos_pkg::POS_LIB_START +: 11];
					end
				endcase
				if (s_q.idx == 2'd2)
				begin
					// Word 2 is mirrored whole; its bits 23:16 also give the extension start
					s_d.epp = cfg_data;
				end
				s_d.idx = s_q.idx + 2'd1;
				if (s_q.idx == 2'd3)
				begin
					s_d.st = ST_DONE;
					s_d.done = 1'b1;
					irq_set[0] = 1'b1;
				end
			end
			ST_DONE:
				s_d.idx = s_q.idx;
			default:
				s_d.st = ST_IDLE;
		endcase
		// Library flags derived from the loaded range and the extension data start sector
		if (s_q.st == ST_DONE)
		begin
			s_d.main_lib_en = (s_q.lib_start <= 11'(s_q.lib_end)) && (s_q.lib_end != fos_pkg::LIB_END_RESET);
			s_d.boot_app = s_q.ext_data_start != 8'h00;
			s_d.ext_lib_en = (s_q.ext_data_start != 8'h00) && s_q.ext_data_start != fos_pkg::EXT_DATA_NONE;
		end
		if (s_q.st == ST_LOAD && s_q.idx == 2'd2)
			s_d.ext_data_start = cfg_data[fos_pkg::POS_EXT_DATA_START +: 8];
		// Flash gate: refused while protection is active
		s_d.grant = flash_req && !level_now[0] && s_q.st == ST_DONE;
		s_d.refused = flash_req && (level_now[0] || s_q.st != ST_DONE);
		if (s_d.refused)
			irq_set[1] = 1'b1;
		// Set wins over a clear written in the same cycle
		s_d.irq_sts = s_q.irq_sts | irq_set;
		// Register bus; loaded status fields ignore writes, interrupt status clears on a written one
		if (wr && addr == fos_pkg::OFS_IRQ_STATUS)
			s_d.irq_sts = (s_q.irq_sts & ~wdata[1:0]) | irq_set;
		if (wr && addr == fos_pkg::OFS_IRQ_MASK)
			s_d.irq_mask = wdata[1:0];
		if (wr && addr == fos_pkg::OFS_LOAD_CTRL && wdata[0])
			s_d.st = ST_IDLE;
		s_d.rdata = 32'h0000_0000;
		if (rd)
		begin
			case (addr)
				fos_pkg::OFS_USER_CONFIG: s_d.rdata = user_word(s_q);
				fos_pkg::OFS_EPP_STATUS: s_d.rdata = s_q.epp;
				fos_pkg::OFS_PLIB_A: s_d.rdata = {8'h00, s_q.ext_data_start, 12'h000, s_q.main_lib_en,
					s_q.ext_lib_en, 1'b0, s_q.boot_app};
				fos_pkg::OFS_PLIB_B: s_d.rdata = {s_q.lib_end, s_q.lib_data_start, s_q.lib_start};
				fos_pkg::OFS_IRQ_STATUS: s_d.rdata = {30'h0, s_q.irq_sts};
				fos_pkg::OFS_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
				fos_pkg::OFS_LOAD_CTRL: s_d.rdata = {31'h0, s_q.st == ST_DONE};
				default: s_d.rdata = 32'h0000_0000;
			endcase
		end
		s_d.irq = |(s_d.irq_sts & s_d.irq_mask);
		if (!s_q.rst_s)
		begin
			s_d.st = ST_IDLE;
			s_d.irq_sts = 2'b00;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			s_q <= '0;
			s_q.st <= ST_IDLE;
			s_q.prot_code <= fos_pkg::PROT_CODE_OFF;
			s_q.user_one <= fos_pkg::BYTE_FORCED;
			s_q.user_zero <= fos_pkg::BYTE_FORCED;
			s_q.sys_byte <= fos_pkg::BYTE_FORCED;
			s_q.epp <= fos_pkg::EPP_RESET;
			s_q.lib_end <= fos_pkg::LIB_END_RESET;
			s_q.lib_start <= fos_pkg::LIB_START_RESET;
		end
		else
			s_q <= s_d;
	end

	assign rdata = s_q.rdata;
	assign cfg_index = s_q.idx;
	assign flash_grant = s_q.grant;
	assign flash_refused = s_q.refused;
	assign load_done = s_q.done;
	assign irq = s_q.irq;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_no_grant_prot: assert property (@(posedge clk) disable iff (!rst_b)
		flash_req && level_now[0] |=> !flash_grant)
		else $error("grant while protected");
	chk_level_code: assert property (@(posedge clk) disable iff (!rst_b)
		rd && addr == fos_pkg::OFS_USER_CONFIG && s_q.prot_code == fos_pkg::PROT_CODE_HIGH
		|=> rdata[fos_pkg::POS_HIGH_LEVEL] && rdata[fos_pkg::POS_ACCESS_PROT])
		else $error("high level not reported");
	chk_err_force: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == ST_LOAD && s_q.idx == 2'd0 && chk_bad[1] |=> s_q.sys_byte == 8'hFF && s_q.usd_err)
		else $error("bad byte not forced");
	chk_ro_epp: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == ST_DONE && !(wr && addr == fos_pkg::OFS_LOAD_CTRL) |=> $stable(s_q.epp))
		else $error("status changed after load");
	chk_ext_needs_boot: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.ext_lib_en |-> s_q.boot_app)
		else $error("extension flag without boot app");
	chk_ext_no_data: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == ST_DONE && s_q.ext_data_start == fos_pkg::EXT_DATA_NONE |=> !s_q.ext_lib_en)
		else $error("extension flag with no data region");
	chk_load_len: assert property (@(posedge clk) disable iff (!rst_b)
		s_q.st == ST_IDLE && s_q.rst_s |=> ##4 load_done)
		else $error("load length wrong");
	chk_lib_read: assert property (@(posedge clk) disable iff (!rst_b)
		rd && addr == fos_pkg::OFS_PLIB_B |=> rdata[31:22] == $past(s_q.lib_end))
		else $error("end sector misplaced");
	chk_irq_level: assert property (@(posedge clk) disable iff (!rst_b)
		irq == |(s_q.irq_sts & s_q.irq_mask))
		else $error("irq disagrees with status and mask");
endmodule : fos_status
`default_nettype wire

// ---- fos_status_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fos_status_tb_top;
	typedef struct packed
	{
		logic [31:0] w0;
		logic [31:0] w1;
		logic [31:0] w2;
		logic [31:0] w3;
		logic [1:0] lvl;
		logic err;
	} fos_row_s;

	logic clk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'h0;
	logic rd = 1'h0;
	logic flash_req = 1'h1;
	logic [31:0] rdata;
	logic [31:0] cfg_data;
	logic [1:0] cfg_index;
	logic flash_grant;
	logic flash_refused;
	logic load_done;
	logic irq;
	logic [31:0] cfg_mem [4] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
	logic [31:0] got;
	logic irq_a;
	int n_mismatch = 0;
	int n_tests = 0;
	// Level {high bit, protect bit} and error flag worked out by hand
	fos_row_s rows [4] = '{
		'{32'h1CE3_5AA5, 32'hCB34_ED12, 32'h0003_C0DE, 32'h043F_F804, 2'h0, 1'h0},
		'{32'h00FF_33CC, 32'h00FF_FF00, 32'h12FF_5678, 32'hFFFF_FFFF, 2'h3, 1'h0},
		'{32'h0007_EE11, 32'hCB34_ED12, 32'h0000_0001, 32'h00C0_0005, 2'h1, 1'h1},
		'{32'h1CE3_00A5, 32'hCB34_ED12, 32'h0080_0000, 32'h0000_0000, 2'h1, 1'h1}};

	assign cfg_data = cfg_mem[cfg_index];

	fos_status dut_u
	(
		.clk(clk),
		.rst_b(rst_b),
		.addr(addr),
		.wdata(wdata),
		.wr(wr),
		.rd(rd),
		.rdata(rdata),
		.cfg_data(cfg_data),
		.cfg_index(cfg_index),
		.flash_req(flash_req),
		.flash_grant(flash_grant),
		.flash_refused(flash_refused),
		.load_done(load_done),
		.irq(irq)
	);

	always #20 clk = ~clk;

	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] seen);
		n_tests++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk32

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask : bus_wr

	// Read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		#1;
		d = rdata;
	endtask : bus_rd

	task automatic wait_load();
		int i;
		for (i = 0; i < 20 && load_done !== 1'h1; i++)
		begin
			@(posedge clk);
			#1;
		end
		chk32("load_done", 32'h0000_0001, {31'h0000_0000, load_done});
	endtask : wait_load

	function automatic logic [7:0] pick(input logic [7:0] b, input logic [7:0] inv);
		return (b === ~inv) ? b : 8'hFF;
	endfunction : pick

	task automatic check_regs(input fos_row_s r);
		logic [31:0] v;
		logic [7:0] ext;
		logic boot;
		logic main_en;
		ext = r.w2[23:16];
		boot = ext != 8'h00;
		main_en = (r.w3[10:0] <= {1'h0, r.w3[31:22]}) && (r.w3[31:22] != 10'h3FF);
		bus_rd(fos_pkg::OFS_USER_CONFIG, v);
		chk32("user_config", {5'h00, r.lvl[1], pick(r.w1[23:16], r.w1[31:24]), pick(r.w1[7:0], r.w1[15:8]),
			pick(r.w0[23:16], r.w0[31:24]), r.lvl[0], r.err}, v);
		bus_rd(fos_pkg::OFS_EPP_STATUS, v);
		chk32("epp_word", r.w2, v);
		bus_rd(fos_pkg::OFS_PLIB_A, v);
		chk32("plib_a", {8'h00, ext, 12'h000, main_en, boot && ext != 8'hFF, 1'h0, boot}, v);
		bus_rd(fos_pkg::OFS_PLIB_B, v);
		chk32("plib_b", r.w3, v);
	endtask : check_regs

	task automatic end_of_test();
		$display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial
	begin
		#400000;
		n_mismatch++;
		end_of_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge clk);
		#1;
		// Flash held off until the first load completes
		chk32("refused_early", 32'h0000_0001, {31'h0000_0000, flash_refused});
		wait_load();
		@(posedge clk);
		flash_req <= 1'h0;
		bus_wr(fos_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		foreach (rows[k])
		begin
			cfg_mem = '{rows[k].w0, rows[k].w1, rows[k].w2, rows[k].w3};
			bus_wr(fos_pkg::OFS_LOAD_CTRL, 32'h0000_0001);
			wait_load();
			check_regs(rows[k]);
			@(posedge clk);
			flash_req <= 1'h1;
			@(posedge clk);
			flash_req <= 1'h0;
			#1;
			chk32("flash_gate", {30'h0000_0000, rows[k].lvl[0], ~rows[k].lvl[0]}, {30'h0000_0000, flash_refused, flash_grant});
		end
		// Writes to status words must not disturb them
		bus_wr(fos_pkg::OFS_USER_CONFIG, 32'h0000_0000);
		bus_wr(fos_pkg::OFS_EPP_STATUS, 32'h0000_0000);
		bus_wr(fos_pkg::OFS_PLIB_A, 32'hFFFF_FFFF);
		bus_wr(fos_pkg::OFS_PLIB_B, 32'h0000_0000);
		check_regs(rows[3]);
		bus_rd(fos_pkg::OFS_LOAD_CTRL, got);
		chk32("loaded", 32'h0000_0001, got & 32'h0000_0001);
		bus_rd(8'h1C, got);
		chk32("unmapped", 32'h0000_0000, got);
		bus_rd(fos_pkg::OFS_IRQ_STATUS, got);
		chk32("irq_status", 32'h0000_0003, got);
		// Mask polarity is the designer's: only require that it changes irq
		bus_wr(fos_pkg::OFS_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge clk);
		#1;
		irq_a = irq;
		bus_wr(fos_pkg::OFS_IRQ_MASK, 32'h0000_0003);
		repeat (2) @(posedge clk);
		#1;
		chk32("irq_mask", 32'h0000_0001, {31'h0000_0000, irq_a ^ irq});
		bus_wr(fos_pkg::OFS_IRQ_STATUS, 32'h0000_0003);
		bus_rd(fos_pkg::OFS_IRQ_STATUS, got);
		chk32("irq_clear", 32'h0000_0000, got);
		#1;
		chk32("irq_low", 32'h0000_0000, {31'h0000_0000, irq});
		// Reset in mid-run: reset values stand until the reload overwrites them
		@(posedge clk);
		rst_b <= 1'h0;
		repeat (3) @(posedge clk);
		rst_b <= 1'h1;
		bus_rd(fos_pkg::OFS_EPP_STATUS, got);
		chk32("epp_reset", fos_pkg::EPP_RESET, got);
		bus_rd(fos_pkg::OFS_PLIB_B, got);
		chk32("plib_b_reset", {fos_pkg::LIB_END_RESET, 11'h000, fos_pkg::LIB_START_RESET}, got);
		wait_load();
		check_regs(rows[3]);
		end_of_test();
	end
endmodule : fos_status_tb_top
`default_nettype wire
